// [fast_counter_status_flags.sv]
// status flags, cause bits and running tally of the fast pulse tally unit
`timescale 1ns/1ps
`include "fast_tally_consts.svh"
module fast_counter_status_flags
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // count steps from the input decoder, same clock
   input wire logic upPulse,
   input wire logic downPulse,
   // avalon-mm slave
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // status for neighbouring logic
   output fast_tally_pkg::status_t statusFlags,
   output logic [31:0] runningTally
);

   function automatic logic isBidir(input fast_tally_pkg::mode_t m);
      isBidir = (m >= `BIDIR_MIN);
   endfunction

   fast_tally_pkg::ctrl_t ctrl;
   fast_tally_pkg::events_t ev;
   logic [31:0] upperSetpoint;
   logic [31:0] lowerSetpoint;
   logic [31:0] overflowLimit;
   logic [31:0] underflowLimit;
   logic [31:0] next_tally;
   logic [31:0] next_readdata;
   logic accept;
   logic wrStatus;
   logic setup;
   logic active;
   logic upStep;
   logic downStep;
   logic single;
   fast_tally_pkg::status_t wd;
   fast_tally_pkg::status_t st;

   // a request is taken only on the edge that sees waitrequest low
   assign accept = (read | write) & ~waitrequest;
   assign wrStatus = accept & write & (address == `OFS_STATUS);
   assign setup = accept & write & (address == `OFS_CTRL)
      & writedata[`CTRL_SETUP];
   assign wd = fast_tally_pkg::status_t'(writedata[`STS_W-1:0]);
   assign single = ~isBidir(ctrl.countingModeSelect);
   assign active = ctrl.countEnable & ctrl.runMode;
   // both pulses at once cancel: no net step
   assign upStep = active & upPulse & ~downPulse;
   assign downStep = active & downPulse & ~upPulse
      & isBidir(ctrl.countingModeSelect);

   // interrupt events, not gated by the interrupt enable; intEnable gates only the cause bits
   always_comb
   begin
      ev.of = upStep & (runningTally == overflowLimit);
      ev.uf = downStep & (runningTally == underflowLimit);
      ev.hp = upStep & (runningTally + 32'h1 == upperSetpoint);
      ev.lp = downStep & (runningTally - 32'h1 == lowerSetpoint);
   end

   // bus handshake: one wait cycle, then a single ready cycle
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         waitrequest <= 1'b1;
      else
         waitrequest <= ~((read | write) & waitrequest);
   end

   always_comb
   begin
      next_readdata = `ZERO32;
      if (address == `OFS_CTRL)
         next_readdata = {24'h000000, ctrl};
      else if (address == `OFS_STATUS)
         next_readdata = {19'h00000, statusFlags};
      else if (address == `OFS_TALLY)
         next_readdata = runningTally;
      else if (address == `OFS_UPPER)
         next_readdata = upperSetpoint;
      else if (address == `OFS_LOWER)
         next_readdata = lowerSetpoint;
      else if (address == `OFS_OVER)
         next_readdata = overflowLimit;
      else if (address == `OFS_UNDER)
         next_readdata = underflowLimit;
   end

   // read data is loaded on the edge that drops waitrequest
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         readdata <= `ZERO32;
      else if (read & waitrequest)
         readdata <= next_readdata;
   end

   // control and limit registers; setup bit is a strobe
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         ctrl <= fast_tally_pkg::ctrl_t'(`ZERO_CTRL);
         upperSetpoint <= `ZERO32;
         lowerSetpoint <= `ZERO32;
         overflowLimit <= `ZERO32;
         underflowLimit <= `ZERO32;
      end
      else
      begin
         ctrl.setup <= 1'b0;
         if (accept & write)
         begin
            if (address == `OFS_CTRL)
               ctrl <= fast_tally_pkg::ctrl_t'(writedata[`CTRL_W-1:0]);
            else if (address == `OFS_UPPER)
               upperSetpoint <= writedata;
            else if (address == `OFS_LOWER)
               lowerSetpoint <= writedata;
            else if (address == `OFS_OVER)
               overflowLimit <= writedata;
            else if (address == `OFS_UNDER)
               underflowLimit <= writedata;
         end
      end
   end

   // running tally
   always_comb
   begin
      next_tally = runningTally;
      if (single & (ev.hp | ev.of))
         next_tally = `ZERO32;
      else if (ev.of)
         next_tally = underflowLimit;
      else if (ev.uf)
         next_tally = overflowLimit;
      else if (upStep)
         next_tally = runningTally + 32'h1;
      else if (downStep)
         next_tally = runningTally - 32'h1;
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n | setup)
         runningTally <= `ZERO32;
      else
         runningTally <= next_tally;
   end

   // flags; hardware set beats a status write clear, but a setup write clears every flag
   always_comb
   begin
      st = statusFlags;
      if (wrStatus)
      begin
         st.singleRunCompletionFlag = wd.singleRunCompletionFlag;
         st.overflowStatusFlag = wd.overflowStatusFlag;
         st.underflowStatusFlag = wd.underflowStatusFlag;
         st.overflowCauseBit = wd.overflowCauseBit;
         st.underflowCauseBit = wd.underflowCauseBit;
         st.upperSetpointCauseBit = wd.upperSetpointCauseBit;
         st.lowerSetpointCauseBit = wd.lowerSetpointCauseBit;
         // reached flag is rewritten from next_tally below in the same cycle whenever runMode is set
         st.upperSetpointReachedFlag = wd.upperSetpointReachedFlag;
      end
      st.countingEnabledStatus = ctrl.countEnable;
      st.upCountingIndicator = ctrl.countEnable;
      st.downCountingIndicator = ctrl.countEnable
         & isBidir(ctrl.countingModeSelect);
      if (single & ev.hp)
         st.singleRunCompletionFlag = 1'b1;
      // no fault path exists; flags are the only record
      if (ev.of)
         st.overflowStatusFlag = 1'b1;
      if (ev.uf)
         st.underflowStatusFlag = 1'b1;
      if (upStep)
         st.directionIndicator = 1'b1;
      else if (downStep)
         st.directionIndicator = 1'b0;
      if (ctrl.runMode)
      begin
         st.upperSetpointReachedFlag =
            $signed(next_tally) >= $signed(upperSetpoint);
         st.lowerSetpointReachedFlag =
            $signed(next_tally) <= $signed(lowerSetpoint);
      end
      if (ctrl.intEnable)
      begin
         if (ev.hp | ev.lp | ev.uf)
            st.overflowCauseBit = 1'b0;
         if (ev.hp | ev.lp | ev.of)
            st.underflowCauseBit = 1'b0;
         if (ev.lp | ev.of | ev.uf)
            st.upperSetpointCauseBit = 1'b0;
         if (ev.hp | ev.of | ev.uf)
            st.lowerSetpointCauseBit = 1'b0;
         if (ev.of)
            st.overflowCauseBit = 1'b1;
         if (ev.uf)
            st.underflowCauseBit = 1'b1;
         if (ev.hp)
            st.upperSetpointCauseBit = 1'b1;
         if (ev.lp)
            st.lowerSetpointCauseBit = 1'b1;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n | setup)
         statusFlags <= fast_tally_pkg::status_t'(`ZERO_STS);
      else
         statusFlags <= st;
   end

   // checks
   AST_UP_IND: assert property (@(posedge clock) disable iff (!rst_n)
      ctrl.countEnable |=> statusFlags.upCountingIndicator | $past(setup))
      else $error("up indicator not set while enabled");

   AST_DOWN_IND: assert property (@(posedge clock) disable iff (!rst_n)
      statusFlags.downCountingIndicator |-> ~$past(single))
      else $error("down indicator set in single mode");

   AST_DONE: assert property (@(posedge clock) disable iff (!rst_n)
      single & ev.hp & ~setup |=> statusFlags.singleRunCompletionFlag)
      else $error("completion flag missed");

   AST_OVF: assert property (@(posedge clock) disable iff (!rst_n)
      ev.of & ~setup |=> statusFlags.overflowStatusFlag)
      else $error("overflow flag missed");

   AST_UNF: assert property (@(posedge clock) disable iff (!rst_n)
      ev.uf & ~setup |=> statusFlags.underflowStatusFlag)
      else $error("underflow flag missed");

   AST_DIR_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
      ~upStep & ~downStep & ~setup |=> $stable(statusFlags.directionIndicator))
      else $error("direction changed without a step");

   AST_DIR_DOWN: assert property (@(posedge clock) disable iff (!rst_n)
      downStep & ~setup |=> ~statusFlags.directionIndicator)
      else $error("direction not cleared on decrement");

   AST_OF_CAUSE: assert property (@(posedge clock) disable iff (!rst_n)
      ctrl.intEnable & ev.uf & ~ev.of & ~setup |=> ~statusFlags.overflowCauseBit)
      else $error("overflow cause not cleared");

   AST_UF_CAUSE: assert property (@(posedge clock) disable iff (!rst_n)
      ctrl.intEnable & ev.uf & ~setup |=> statusFlags.underflowCauseBit)
      else $error("underflow cause not set");

   AST_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
      single & ev.hp & ~setup |=> runningTally == `ZERO32)
      else $error("tally not zeroed");

   AST_SETUP: assert property (@(posedge clock) disable iff (!rst_n)
      setup |=> statusFlags == fast_tally_pkg::status_t'(`ZERO_STS))
      else $error("flags not cleared by setup");

   AST_WAIT: assert property (@(posedge clock) disable iff (!rst_n)
      (read | write) & waitrequest |=> ~waitrequest ##1 waitrequest)
      else $error("bus answer not one cycle");

   AST_UP_CLR: assert property (@(posedge clock) disable iff (!rst_n)
      ~ctrl.countEnable |=> ~statusFlags.upCountingIndicator)
      else $error("up indicator set while disabled");

   AST_DOWN_SET: assert property (@(posedge clock) disable iff (!rst_n)
      ctrl.countEnable & ~single & ~setup |=> statusFlags.downCountingIndicator)
      else $error("down indicator not set in bidirectional mode");

   AST_EN_STS: assert property (@(posedge clock) disable iff (!rst_n)
      ~setup |=> statusFlags.countingEnabledStatus == $past(ctrl.countEnable))
      else $error("counting enabled status differs from enable");

   AST_OVF_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
      statusFlags.overflowStatusFlag & ~wrStatus & ~setup |=> statusFlags.overflowStatusFlag)
      else $error("overflow flag cleared by hardware");

   AST_UNF_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
      statusFlags.underflowStatusFlag & ~wrStatus & ~setup
         |=> statusFlags.underflowStatusFlag)
      else $error("underflow flag cleared by hardware");

   AST_DIR_UP: assert property (@(posedge clock) disable iff (!rst_n)
      upStep & ~setup |=> statusFlags.directionIndicator)
      else $error("direction not set on increment");

   // tally after the edge is the next tally that the flag was built from
   AST_HP_REACHED: assert property (@(posedge clock) disable iff (!rst_n)
      ctrl.runMode & ~setup |=> statusFlags.upperSetpointReachedFlag
         == ($signed(runningTally) >= $signed($past(upperSetpoint))))
      else $error("upper reached flag wrong");

   AST_LP_REACHED: assert property (@(posedge clock) disable iff (!rst_n)
      ctrl.runMode & ~setup |=> statusFlags.lowerSetpointReachedFlag
         == ($signed(runningTally) <= $signed($past(lowerSetpoint))))
      else $error("lower reached flag wrong");

   AST_OF_CAUSE_SET: assert property (@(posedge clock) disable iff (!rst_n)
      ctrl.intEnable & ev.of & ~setup |=> statusFlags.overflowCauseBit)
      else $error("overflow cause not set");

   AST_UF_CAUSE_CLR: assert property (@(posedge clock) disable iff (!rst_n)
      ctrl.intEnable & (ev.hp | ev.lp | ev.of) & ~ev.uf & ~setup
         |=> ~statusFlags.underflowCauseBit)
      else $error("underflow cause not cleared");

   AST_HP_CAUSE: assert property (@(posedge clock) disable iff (!rst_n)
      ctrl.intEnable & ev.hp & ~setup |=> statusFlags.upperSetpointCauseBit)
      else $error("upper cause not set");

   AST_HP_CAUSE_CLR: assert property (@(posedge clock) disable iff (!rst_n)
      ctrl.intEnable & (ev.lp | ev.of | ev.uf) & ~ev.hp & ~setup
         |=> ~statusFlags.upperSetpointCauseBit)
      else $error("upper cause not cleared");

   AST_LP_CAUSE: assert property (@(posedge clock) disable iff (!rst_n)
      ctrl.intEnable & ev.lp & ~setup |=> statusFlags.lowerSetpointCauseBit)
      else $error("lower cause not set");

   AST_LP_CAUSE_CLR: assert property (@(posedge clock) disable iff (!rst_n)
      ctrl.intEnable & (ev.hp | ev.of | ev.uf) & ~ev.lp & ~setup
         |=> ~statusFlags.lowerSetpointCauseBit)
      else $error("lower cause not cleared");

   AST_ZERO_OF: assert property (@(posedge clock) disable iff (!rst_n)
      single & ev.of & ~setup |=> runningTally == `ZERO32)
      else $error("tally not zeroed on overflow");

   // cause bits only move on interrupts, a software write or setup
   AST_CAUSE_QUIET: assert property (@(posedge clock) disable iff (!rst_n)
      ~ctrl.intEnable & ~wrStatus & ~setup |=> $stable(statusFlags.overflowCauseBit))
      else $error("overflow cause moved without interrupt");

   AST_SETUP_TALLY: assert property (@(posedge clock) disable iff (!rst_n)
      setup |=> runningTally == `ZERO32)
      else $error("tally not cleared by setup");

   AST_READ_TALLY: assert property (@(posedge clock) disable iff (!rst_n)
      read & waitrequest & (address == `OFS_TALLY) |=> readdata == $past(runningTally))
      else $error("tally read data wrong");

   COV_OF: cover property (@(posedge clock) disable iff (!rst_n) ev.of);
   COV_HP: cover property (@(posedge clock) disable iff (!rst_n) ev.hp & single);
   COV_UF: cover property (@(posedge clock) disable iff (!rst_n) ev.uf);
   COV_LP: cover property (@(posedge clock) disable iff (!rst_n) ev.lp);
   COV_REV: cover property (@(posedge clock) disable iff (!rst_n)
      upStep ##[1:20] downStep);
endmodule

// [fast_tally_consts.svh]
// offsets, field positions and reset values of the tally status block
`ifndef FAST_TALLY_CONSTS_SVH
`define FAST_TALLY_CONSTS_SVH
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_TALLY 8'h08
`define OFS_UPPER 8'h0C
`define OFS_LOWER 8'h10
`define OFS_OVER 8'h14
`define OFS_UNDER 8'h18
`define CTRL_EN 0
`define CTRL_MODE_LO 1
`define CTRL_MODE_HI 4
`define CTRL_SETUP 5
`define CTRL_RUN 6
`define CTRL_INT 7
`define CTRL_W 8
`define STS_W 13
`define BIDIR_MIN 4'h2
`define ZERO32 32'h0000_0000
`define ZERO_CTRL 8'h00
`define ZERO_STS 13'h0000
`endif

// [fast_tally_pkg.sv]
// types shared by the tally status block
package fast_tally_pkg;
   typedef logic [3:0] mode_t;
   typedef struct packed {
      logic countingEnabledStatus;
      logic lowerSetpointCauseBit;
      logic upperSetpointCauseBit;
      logic underflowCauseBit;
      logic overflowCauseBit;
      logic lowerSetpointReachedFlag;
      logic upperSetpointReachedFlag;
      logic directionIndicator;
      logic underflowStatusFlag;
      logic overflowStatusFlag;
      logic singleRunCompletionFlag;
      logic downCountingIndicator;
      logic upCountingIndicator;
   } status_t;
   typedef struct packed {
      logic intEnable;
      logic runMode;
      logic setup;
      mode_t countingModeSelect;
      logic countEnable;
   } ctrl_t;
   typedef struct packed {
      logic hp;
      logic lp;
      logic of;
      logic uf;
   } events_t;
endpackage

// [test_fast_counter_status_flags.sv]
// self-checking testbench for the fast pulse tally status block
`timescale 1ns/1ps
`include "fast_tally_consts.svh"
module test_fast_counter_status_flags;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic upPulse = 1'b0;
   logic downPulse = 1'b0;
   logic [7:0] address = 8'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0000_0000;
   logic [31:0] readdata;
   logic waitrequest;
   fast_tally_pkg::status_t statusFlags;
   logic [31:0] runningTally;
   logic [31:0] q;
   int nFail = 0;
   int checksDone = 0;
   always #5 clock = ~clock;
   fast_counter_status_flags DUT
   (
      .clock(clock),
      .rst_n(rst_n),
      .upPulse(upPulse),
      .downPulse(downPulse),
      .address(address),
      .read(read),
      .write(write),
      .writedata(writedata),
      .readdata(readdata),
      .waitrequest(waitrequest),
      .statusFlags(statusFlags),
      .runningTally(runningTally)
   );
   task automatic stop_test();
      if (nFail == 0 && checksDone > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp)
      begin
         nFail++;
         $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one avalon transfer; request held until waitrequest sampled low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      address <= a;
      write <= wr;
      read <= ~wr;
      writedata <= d;
      @(posedge clock);
      while (waitrequest !== 1'b0 && n < 50)
      begin
         n++;
         @(posedge clock);
      end
      if (n >= 50)
         nFail++;
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
      // registered flags need a cycle beyond the write edge
      repeat (2) @(negedge clock);
   endtask
   task automatic step(input logic u, input logic d, input int n);
      @(posedge clock);
      upPulse <= u;
      downPulse <= d;
      repeat (n) @(posedge clock);
      upPulse <= 1'b0;
      downPulse <= 1'b0;
      repeat (2) @(negedge clock);
   endtask
   task automatic t_reset();
      chk(32'(statusFlags), 32'h0000_0000);
      bus(1'b0, `OFS_STATUS, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      bus(1'b0, `OFS_TALLY, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      bus(1'b0, 8'h40, 32'h0000_0000);
      chk(q, 32'h0000_0000);
   endtask
   task automatic t_enable();
      bus(1'b1, `OFS_UPPER, 32'h0000_0005);
      bus(1'b1, `OFS_LOWER, 32'hFFFF_FFFD);
      bus(1'b1, `OFS_OVER, 32'h0000_0008);
      bus(1'b1, `OFS_UNDER, 32'hFFFF_FFFA);
      bus(1'b1, `OFS_CTRL, 32'h0000_00C1);
      chk(32'(statusFlags.upCountingIndicator), 32'h1);
      chk(32'(statusFlags.downCountingIndicator), 32'h0);
      bus(1'b1, `OFS_CTRL, 32'h0000_00C5);
      chk(32'(statusFlags), 32'h0000_1003);
      bus(1'b1, `OFS_CTRL, 32'h0000_00C4);
      chk(32'(statusFlags.countingEnabledStatus), 32'h0);
      chk(32'(statusFlags.upCountingIndicator), 32'h0);
      chk(32'(statusFlags.downCountingIndicator), 32'h0);
      bus(1'b1, `OFS_CTRL, 32'h0000_00C5);
   endtask
   // bidirectional walk through upper, lower, underflow and overflow
   task automatic t_walk();
      step(1'b1, 1'b0, 5);
      chk(runningTally, 32'h0000_0005);
      chk(32'(statusFlags.directionIndicator), 32'h1);
      chk(32'(statusFlags.upperSetpointReachedFlag), 32'h1);
      chk(32'(statusFlags.upperSetpointCauseBit), 32'h1);
      repeat (4) @(negedge clock);
      chk(32'(statusFlags.directionIndicator), 32'h1);
      step(1'b0, 1'b1, 1);
      chk(32'(statusFlags.directionIndicator), 32'h0);
      chk(32'(statusFlags.upperSetpointReachedFlag), 32'h0);
      step(1'b0, 1'b1, 7);
      chk(runningTally, 32'hFFFF_FFFD);
      chk(32'(statusFlags.lowerSetpointReachedFlag), 32'h1);
      chk(32'(statusFlags.lowerSetpointCauseBit), 32'h1);
      chk(32'(statusFlags.upperSetpointCauseBit), 32'h0);
      step(1'b0, 1'b1, 4);
      chk(runningTally, 32'h0000_0008);
      chk(32'(statusFlags.underflowStatusFlag), 32'h1);
      chk(32'(statusFlags.underflowCauseBit), 32'h1);
      chk(32'(statusFlags.lowerSetpointCauseBit), 32'h0);
      step(1'b1, 1'b0, 1);
      chk(runningTally, 32'hFFFF_FFFA);
      chk(32'(statusFlags.overflowStatusFlag), 32'h1);
      chk(32'(statusFlags.overflowCauseBit), 32'h1);
      chk(32'(statusFlags.underflowCauseBit), 32'h0);
      chk(32'(statusFlags.underflowStatusFlag), 32'h1);
      step(1'b1, 1'b0, 11);
      chk(32'(statusFlags.overflowCauseBit), 32'h0);
      chk(32'(statusFlags.upperSetpointCauseBit), 32'h1);
      chk(32'(statusFlags.overflowStatusFlag), 32'h1);
      // software clears; direction is read only and must survive
      bus(1'b1, `OFS_STATUS, 32'h0000_0040);
      chk(32'(statusFlags.upperSetpointReachedFlag), 32'h1);
      chk(32'(statusFlags.overflowStatusFlag), 32'h0);
      chk(32'(statusFlags.underflowStatusFlag), 32'h0);
      chk(32'(statusFlags.upperSetpointCauseBit), 32'h0);
      chk(32'(statusFlags.directionIndicator), 32'h1);
   endtask
   task automatic t_single();
      bus(1'b1, `OFS_CTRL, 32'h0000_0020);
      chk(32'(statusFlags), 32'h0000_0000);
      chk(runningTally, 32'h0000_0000);
      bus(1'b1, `OFS_CTRL, 32'h0000_00C1);
      step(1'b1, 1'b0, 5);
      chk(runningTally, 32'h0000_0000);
      chk(32'(statusFlags.singleRunCompletionFlag), 32'h1);
      bus(1'b0, `OFS_STATUS, 32'h0000_0000);
      chk(q & 32'h0000_0004, 32'h0000_0004);
      // upper setpoint above the overflow limit so overflow is reached first
      bus(1'b1, `OFS_UPPER, 32'h0000_0010);
      step(1'b1, 1'b0, 9);
      chk(runningTally, 32'h0000_0000);
      chk(32'(statusFlags.overflowStatusFlag), 32'h1);
      step(1'b0, 1'b1, 2);
      chk(runningTally, 32'h0000_0000);
      chk(32'(statusFlags.downCountingIndicator), 32'h0);
      chk(32'(statusFlags.directionIndicator), 32'h1);
   endtask
   initial
   begin
      // generous bound on a run of under two hundred cycles
      #200000;
      nFail++;
      stop_test();
   end
   initial
   begin
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      @(negedge clock);
      t_reset();
      t_enable();
      t_walk();
      t_single();
      stop_test();
   end
endmodule
